// ---- core/gpca_map.svh ----
// Constants of the GPIO pin configuration access block
// Function
// (RQ1) Activate register at 30h, resets zero
// (RQ2) Base address 60h/61h, low nibble reads zero
// (RQ3) Interrupt type 71h, reset 03h, bit1 writable
// (RQ4) Indexes 74h and 75h read 04h
// (RQ5) Pin-select register at F0h, resets zero
// (RQ6) Port field bits 6-4 codes 0-4
// (RQ7) Pin field bits 2-0 selects bit
// (RQ8) F1h reaches selected pin's own byte
// (RQ9) Reset 44h ports 0,1,4; 04h ports 2,3
// (RQ10) Bit 6 enables event debounce filter
// (RQ11) Bit 5 selects event polarity
// (RQ12) Bit 4 selects edge or level
// (RQ13) Ports 2,3 bits 6-4 read zero
// (RQ14) Routing register F2h steers pin events
// (RQ15) Bit 3 sticky lock freezes drive bits
// (RQ16) Bits 2,1,0: pull-up, push-pull, enable
// (RQ17) Routing bits: irq, smi, wake-up
// (RQ18) Reserved port code: window ignored, reads zero
`ifndef GPCA_MAP_SVH
`define GPCA_MAP_SVH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define GPCA_IDX_ACTIVATE 8'h30
`define GPCA_IDX_BASE_HIGH 8'h60
`define GPCA_IDX_BASE_LOW 8'h61
`define GPCA_IDX_IRQ_NUMBER 8'h70
`define GPCA_IDX_IRQ_TYPE 8'h71
`define GPCA_IDX_DMA_FIRST 8'h74
`define GPCA_IDX_DMA_SECOND 8'h75
`define GPCA_IDX_PIN_SELECT 8'hf0
`define GPCA_IDX_PIN_WINDOW 8'hf1
`define GPCA_IDX_ROUTING 8'hf2
`define GPCA_IDX_STATUS_P0 8'hf3
`define GPCA_IDX_STATUS_P1 8'hf4
`define GPCA_IDX_STATUS_P4 8'hf5
`define GPCA_IDX_MASK_P0 8'hf6
`define GPCA_IDX_MASK_P1 8'hf7
`define GPCA_IDX_MASK_P4 8'hf8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPCA_CFG_DEBOUNCE 6
`define GPCA_CFG_POLARITY 5
`define GPCA_CFG_LEVEL 4
`define GPCA_CFG_LOCK 3
`define GPCA_CFG_PULLUP 2
`define GPCA_CFG_PUSHPULL 1
`define GPCA_CFG_OUTEN 0
`define GPCA_ROUTE_IRQ 0
`define GPCA_ROUTE_SMI 1
`define GPCA_ROUTE_WAKE 2
`define GPCA_ITYPE_RW_BIT 1

// ----------------------------------------
// Reset and fixed values, sizes
// ----------------------------------------
`define GPCA_CFG_RST_EVENT 8'h44
`define GPCA_CFG_RST_PLAIN 8'h04
`define GPCA_ITYPE_FIXED 8'h01
`define GPCA_ITYPE_RST_BIT 1'h1
`define GPCA_DMA_NONE 8'h04
`define GPCA_PORT_LAST 3'h4
`define GPCA_PORT_PLAIN_A 3'h2
`define GPCA_PORT_PLAIN_B 3'h3
`define GPCA_PORT3_PINS 3'h5
`define GPCA_NUM_PINS 40
`define GPCA_NUM_EVENTS 24
`define GPCA_EVENT_SPLIT 16
`define GPCA_EVENT_SHIFT 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define GPCA_CLK_PERIOD_NS 50
`define GPCA_DEBOUNCE_NS 1000
`define GPCA_DEBOUNCE_CYC ((`GPCA_DEBOUNCE_NS + `GPCA_CLK_PERIOD_NS - 1) / `GPCA_CLK_PERIOD_NS)
`define GPCA_CNT_W 5

`endif

// ---- core/gpca_pkg.sv ----
// Types of the GPIO pin configuration access block
`include "gpca_map.svh"
package gpca_pkg;

  // ----------------------------------------
  // Whole block state
  // ----------------------------------------
  typedef struct packed {
    logic activate;
    logic [7:0] base_high;
    logic [3:0] base_low_upper;
    logic [7:0] irq_number;
    logic irq_type_bit;
    logic [2:0] sel_port;
    logic [2:0] sel_pin;
    logic [2:0] routing;
    logic [`GPCA_NUM_PINS-1:0][7:0] cfg;
    logic [`GPCA_NUM_EVENTS-1:0] status;
    logic [`GPCA_NUM_EVENTS-1:0] mask;
    logic [`GPCA_NUM_EVENTS-1:0] filtered;
    logic [`GPCA_NUM_EVENTS-1:0] prev_active;
    logic [`GPCA_NUM_EVENTS-1:0][`GPCA_CNT_W-1:0] count;
    logic [7:0] rd_data;
    logic irq;
    logic smi;
    logic wake;
  } gpca_state_t;

endpackage

// ---- core/gpca_pin_config.sv ----
// GPIO configuration-space registers, per-pin window and event routing
`timescale 1ns/1ps
`default_nettype none
`include "gpca_map.svh"
module gpca_pin_config
  import gpca_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_write_i,
  input wire logic cfg_read_i,
  input wire logic [`GPCA_NUM_PINS-1:0] pin_level_i,
  output logic [7:0] cfg_rdata_o,
  output logic function_active_o,
  output logic [15:0] base_address_o,
  output logic [7:0] irq_number_o,
  output logic irq_type_o,
  output logic [2:0] event_routing_o,
  output logic [`GPCA_NUM_PINS-1:0] pullup_en_o,
  output logic [`GPCA_NUM_PINS-1:0] push_pull_o,
  output logic [`GPCA_NUM_PINS-1:0] drive_en_o,
  output logic [`GPCA_NUM_PINS-1:0] pin_lock_o,
  output logic irq_o,
  output logic smi_o,
  output logic power_wakeup_request_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Async assertion, clocked release, so no flop leaves reset on a runt edge
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Reset image
  // ----------------------------------------
  // Port order from the top: 4, 3, 2, 1, 0
  localparam logic [`GPCA_NUM_PINS-1:0][7:0] CFG_RESET = {
    {8{`GPCA_CFG_RST_EVENT}},
    {8{`GPCA_CFG_RST_PLAIN}},
    {8{`GPCA_CFG_RST_PLAIN}},
    {8{`GPCA_CFG_RST_EVENT}},
    {8{`GPCA_CFG_RST_EVENT}}
  }; // [RQ9]

  localparam gpca_state_t STATE_RESET = '{
    activate: 1'b0,
    base_high: 8'h00,
    base_low_upper: 4'h0,
    irq_number: 8'h00,
    irq_type_bit: `GPCA_ITYPE_RST_BIT,
    sel_port: 3'h0,
    sel_pin: 3'h0,
    routing: 3'h0,
    cfg: CFG_RESET,
    status: '0,
    mask: '0,
    filtered: '0,
    prev_active: '0,
    count: '0,
    rd_data: 8'h00,
    irq: 1'b0,
    smi: 1'b0,
    wake: 1'b0
  };

  localparam logic [`GPCA_CNT_W-1:0] DEB_LAST = `GPCA_CNT_W'(`GPCA_DEBOUNCE_CYC - 1);

  gpca_state_t state_reg;
  gpca_state_t state_next;

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  logic [5:0] sel_index;
  logic sel_valid;
  logic sel_plain;

  assign sel_index = {state_reg.sel_port, state_reg.sel_pin}; // [RQ6] [RQ7]
  // Reserved port codes and the missing upper pins of port 3 reach nothing
  assign sel_valid = (state_reg.sel_port <= `GPCA_PORT_LAST) &&
                     !((state_reg.sel_port == `GPCA_PORT_PLAIN_B) &&
                       (state_reg.sel_pin >= `GPCA_PORT3_PINS)); // [RQ18]
  assign sel_plain = (state_reg.sel_port == `GPCA_PORT_PLAIN_A) ||
                     (state_reg.sel_port == `GPCA_PORT_PLAIN_B);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] old_cfg;
    logic [7:0] new_cfg;
    logic [`GPCA_NUM_EVENTS-1:0] ev_set;
    logic [`GPCA_NUM_EVENTS-1:0] ev_clr;
    logic [`GPCA_NUM_EVENTS-1:0] pending;
    logic [7:0] pcfg;
    logic raw;
    logic act;
    wr = cfg_write_i;
    rd = cfg_read_i;
    old_cfg = 8'h00;
    new_cfg = 8'h00;
    ev_set = '0;
    ev_clr = '0;
    pending = '0;
    pcfg = 8'h00;
    raw = 1'b0;
    act = 1'b0;
    state_next = state_reg;

    // Plain register writes
    if (wr) begin
      unique case (cfg_addr_i)
        `GPCA_IDX_ACTIVATE: state_next.activate = cfg_wdata_i[0]; // [RQ1]
        `GPCA_IDX_BASE_HIGH: state_next.base_high = cfg_wdata_i; // [RQ2]
        `GPCA_IDX_BASE_LOW: state_next.base_low_upper = cfg_wdata_i[7:4]; // [RQ2]
        `GPCA_IDX_IRQ_NUMBER: state_next.irq_number = cfg_wdata_i;
        `GPCA_IDX_IRQ_TYPE: state_next.irq_type_bit = cfg_wdata_i[`GPCA_ITYPE_RW_BIT]; // [RQ3]
        `GPCA_IDX_PIN_SELECT: begin
          state_next.sel_port = cfg_wdata_i[6:4]; // [RQ5] [RQ6]
          state_next.sel_pin = cfg_wdata_i[2:0]; // [RQ7]
        end
        `GPCA_IDX_ROUTING: state_next.routing = cfg_wdata_i[2:0]; // [RQ14] [RQ17]
        `GPCA_IDX_MASK_P0: state_next.mask[7:0] = cfg_wdata_i;
        `GPCA_IDX_MASK_P1: state_next.mask[15:8] = cfg_wdata_i;
        `GPCA_IDX_MASK_P4: state_next.mask[23:16] = cfg_wdata_i;
        default: begin
        end
      endcase
    end

    // Window write into the selected pin's own byte
    if (wr && (cfg_addr_i == `GPCA_IDX_PIN_WINDOW) && sel_valid) begin // [RQ8] [RQ18]
      old_cfg = state_reg.cfg[sel_index];
      new_cfg = cfg_wdata_i;
      new_cfg[7] = 1'b0;
      if (sel_plain) begin
        new_cfg[6:4] = 3'h0; // [RQ13]
      end
      // Lock is sticky and freezes drive settings until reset
      if (old_cfg[`GPCA_CFG_LOCK]) begin
        new_cfg[3:0] = old_cfg[3:0]; // [RQ15]
      end
      state_next.cfg[sel_index] = new_cfg; // [RQ16]
    end

    // Status read clears its byte
    if (rd) begin
      unique case (cfg_addr_i)
        `GPCA_IDX_STATUS_P0: ev_clr[7:0] = 8'hff;
        `GPCA_IDX_STATUS_P1: ev_clr[15:8] = 8'hff;
        `GPCA_IDX_STATUS_P4: ev_clr[23:16] = 8'hff;
        default: begin
        end
      endcase
    end

    // Per-pin event detection on ports 0, 1 and 4
    for (int e = 0; e < `GPCA_NUM_EVENTS; e++) begin
      if (e < `GPCA_EVENT_SPLIT) begin
        pcfg = state_reg.cfg[e];
        raw = pin_level_i[e];
      end else begin
        pcfg = state_reg.cfg[e + `GPCA_EVENT_SHIFT];
        raw = pin_level_i[e + `GPCA_EVENT_SHIFT];
      end
      if (!pcfg[`GPCA_CFG_DEBOUNCE]) begin
        state_next.filtered[e] = raw;
        state_next.count[e] = '0;
      end else if (raw == state_reg.filtered[e]) begin
        state_next.count[e] = '0;
      end else if (state_reg.count[e] == DEB_LAST) begin
        // Change passes only after staying stable the whole period
        state_next.filtered[e] = raw; // [RQ10]
        state_next.count[e] = '0;
      end else begin
        state_next.count[e] = state_reg.count[e] + `GPCA_CNT_W'(1); // [RQ10]
      end
      act = pcfg[`GPCA_CFG_POLARITY] ? state_reg.filtered[e]
                                      : !state_reg.filtered[e]; // [RQ11]
      state_next.prev_active[e] = act;
      if (pcfg[`GPCA_CFG_LEVEL]) begin
        ev_set[e] = act && state_reg.activate; // [RQ12]
      end else begin
        ev_set[e] = act && !state_reg.prev_active[e] && state_reg.activate; // [RQ12]
      end
    end

    // An event in the clearing cycle survives the clear
    state_next.status = (state_reg.status & ~ev_clr) | ev_set;

    // Routed outputs follow the unmasked sticky bits
    pending = state_next.status & state_next.mask;
    state_next.irq = state_next.activate && (|pending) &&
                     state_next.routing[`GPCA_ROUTE_IRQ]; // [RQ17]
    state_next.smi = state_next.activate && (|pending) &&
                     state_next.routing[`GPCA_ROUTE_SMI]; // [RQ17]
    state_next.wake = state_next.activate && (|pending) &&
                      state_next.routing[`GPCA_ROUTE_WAKE]; // [RQ17]

    // Read data stands only in the cycle after the strobe
    state_next.rd_data = 8'h00;
    if (rd) begin
      unique case (cfg_addr_i)
        `GPCA_IDX_ACTIVATE: state_next.rd_data = {7'h00, state_reg.activate}; // [RQ1]
        `GPCA_IDX_BASE_HIGH: state_next.rd_data = state_reg.base_high;
        `GPCA_IDX_BASE_LOW: state_next.rd_data = {state_reg.base_low_upper, 4'h0}; // [RQ2]
        `GPCA_IDX_IRQ_NUMBER: state_next.rd_data = state_reg.irq_number;
        `GPCA_IDX_IRQ_TYPE: state_next.rd_data = `GPCA_ITYPE_FIXED |
            {6'h00, state_reg.irq_type_bit, 1'b0}; // [RQ3]
        `GPCA_IDX_DMA_FIRST: state_next.rd_data = `GPCA_DMA_NONE; // [RQ4]
        `GPCA_IDX_DMA_SECOND: state_next.rd_data = `GPCA_DMA_NONE; // [RQ4]
        `GPCA_IDX_PIN_SELECT: state_next.rd_data = {1'b0, state_reg.sel_port, 1'b0,
            state_reg.sel_pin}; // [RQ5]
        `GPCA_IDX_PIN_WINDOW: state_next.rd_data = sel_valid ? state_reg.cfg[sel_index]
            : 8'h00; // [RQ8] [RQ18]
        `GPCA_IDX_ROUTING: state_next.rd_data = {5'h00, state_reg.routing}; // [RQ14]
        `GPCA_IDX_STATUS_P0: state_next.rd_data = state_reg.status[7:0];
        `GPCA_IDX_STATUS_P1: state_next.rd_data = state_reg.status[15:8];
        `GPCA_IDX_STATUS_P4: state_next.rd_data = state_reg.status[23:16];
        `GPCA_IDX_MASK_P0: state_next.rd_data = state_reg.mask[7:0];
        `GPCA_IDX_MASK_P1: state_next.rd_data = state_reg.mask[15:8];
        `GPCA_IDX_MASK_P4: state_next.rd_data = state_reg.mask[23:16];
        default: state_next.rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cfg_rdata_o = state_reg.rd_data;
  assign function_active_o = state_reg.activate;
  assign base_address_o = {state_reg.base_high, state_reg.base_low_upper, 4'h0};
  assign irq_number_o = state_reg.irq_number;
  assign irq_type_o = state_reg.irq_type_bit;
  assign event_routing_o = state_reg.routing;
  assign irq_o = state_reg.irq;
  assign smi_o = state_reg.smi;
  assign power_wakeup_request_o = state_reg.wake;

  genvar p;
  generate
    for (p = 0; p < `GPCA_NUM_PINS; p++) begin : g_pin
      assign pullup_en_o[p] = state_reg.cfg[p][`GPCA_CFG_PULLUP]; // [RQ16]
      assign push_pull_o[p] = state_reg.cfg[p][`GPCA_CFG_PUSHPULL]; // [RQ16]
      assign drive_en_o[p] = state_reg.cfg[p][`GPCA_CFG_OUTEN]; // [RQ16]
      assign pin_lock_o[p] = state_reg.cfg[p][`GPCA_CFG_LOCK]; // [RQ15]
    end
  endgenerate

endmodule
`default_nettype wire

// ---- sim/gpca_pin_config_sva.sv ----
// Port checker of the GPIO pin configuration access block
`timescale 1ns/1ps
`default_nettype none
`include "gpca_map.svh"
module gpca_pin_config_sva (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_write_i,
  input wire logic cfg_read_i,
  input wire logic [`GPCA_NUM_PINS-1:0] pin_level_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic function_active_o,
  input wire logic [15:0] base_address_o,
  input wire logic [7:0] irq_number_o,
  input wire logic irq_type_o,
  input wire logic [2:0] event_routing_o,
  input wire logic [`GPCA_NUM_PINS-1:0] pullup_en_o,
  input wire logic [`GPCA_NUM_PINS-1:0] push_pull_o,
  input wire logic [`GPCA_NUM_PINS-1:0] drive_en_o,
  input wire logic [`GPCA_NUM_PINS-1:0] pin_lock_o,
  input wire logic irq_o,
  input wire logic smi_o,
  input wire logic power_wakeup_request_o
);
  // ----
  // Bus, routing and lock properties
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_at(logic [7:0] a);
    cfg_read_i && cfg_addr_i == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    cfg_write_i && cfg_addr_i == a;
  endsequence
  a_rdata_idle: assert property (!$past(cfg_read_i) |-> cfg_rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_dma_report: assert property (
    cfg_read_i && cfg_addr_i[7:1] == 7'h3a |=> cfg_rdata_o == `GPCA_DMA_NONE)
    else $error("dma report value");
  a_itype_read: assert property (
    rd_at(`GPCA_IDX_IRQ_TYPE) |=> cfg_rdata_o == {6'h00, irq_type_o, 1'b1})
    else $error("interrupt type read");
  a_route_read: assert property (
    rd_at(`GPCA_IDX_ROUTING) |=> cfg_rdata_o == {5'h00, event_routing_o})
    else $error("routing read");
  a_activate_write: assert property (
    wr_at(`GPCA_IDX_ACTIVATE) |=> function_active_o == $past(cfg_wdata_i[0]))
    else $error("activate write");
  a_base_low: assert property (
    wr_at(`GPCA_IDX_BASE_LOW) |=> base_address_o[7:0] == {$past(cfg_wdata_i[7:4]), 4'h0})
    else $error("base low write");
  a_route_gate: assert property (
    !function_active_o && !$past(function_active_o)
    |-> !(irq_o || smi_o || power_wakeup_request_o))
    else $error("event output while inactive");
  a_irq_routed: assert property (
    irq_o |-> function_active_o && event_routing_o[`GPCA_ROUTE_IRQ])
    else $error("interrupt without its route");
  a_lock_sticky: assert property (($past(pin_lock_o) & ~pin_lock_o) == '0)
    else $error("lock bit cleared");
  a_lock_freeze: assert property (
    ($past(pin_lock_o) & ((drive_en_o ^ $past(drive_en_o))
    | (push_pull_o ^ $past(push_pull_o)) | (pullup_en_o ^ $past(pullup_en_o)))) == '0)
    else $error("locked pin changed");
endmodule
bind gpca_pin_config gpca_pin_config_sva chk_u (.*);
`default_nettype wire

// ---- sim/gpca_pin_config_bench.sv ----
// Self-checking bench of the GPIO pin configuration access block
`timescale 1ns/1ps
`default_nettype none
`include "gpca_map.svh"
module gpca_pin_config_bench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic cfg_write_i = 1'b0;
  logic cfg_read_i = 1'b0;
  logic [39:0] pin_level_i = '0;
  logic [7:0] cfg_rdata_o;
  logic function_active_o;
  logic [15:0] base_address_o;
  logic [7:0] irq_number_o;
  logic irq_type_o;
  logic [2:0] event_routing_o;
  logic [39:0] pullup_en_o, push_pull_o, drive_en_o, pin_lock_o;
  logic irq_o, smi_o, power_wakeup_request_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int k;
  logic [31:0] seed = 32'h00002d6c;
  logic [7:0] exp_cfg [40];
  logic [7:0] v, d;
  logic ok;
  gpca_pin_config dut_u (.*);
  initial forever #25 core_clk_i = ~core_clk_i;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Locked pins keep bits 3..0; event bits stay writable
  function automatic logic [7:0] cfg_after(logic [7:0] o, logic [7:0] n, logic [2:0] p);
    logic [7:0] m;
    m = (p == 3'h2 || p == 3'h3) ? 8'h0f : 8'h7f;
    return o[3] ? ((n & m & 8'h70) | {4'h0, o[3:0]}) : (n & m);
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] x);
    @(posedge core_clk_i);
    cfg_addr_i <= a;
    cfg_wdata_i <= x;
    cfg_write_i <= 1'b1;
    @(posedge core_clk_i);
    cfg_write_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk_i);
    cfg_addr_i <= a;
    cfg_read_i <= 1'b1;
    @(posedge core_clk_i);
    cfg_read_i <= 1'b0;
    @(negedge core_clk_i);
    chk(cfg_rdata_o, exp, "read data");
    // Return on a rising edge so callers drive inputs there
    @(posedge core_clk_i);
  endtask
  task automatic pins(int i);
    chk({4'h0, pin_lock_o[i], pullup_en_o[i], push_pull_o[i], drive_en_o[i]},
        exp_cfg[i] & 8'h0f, "pin outputs");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 1500 cycles the tests need
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    tick(4);
    rst_n_i <= 1'b1;
    tick(4);
    rd(8'h30, 8'h00);
    rd(8'h61, 8'h00);
    rd(8'h71, 8'h03);
    rd(8'h74, 8'h04);
    rd(8'hf0, 8'h00);
    rd(8'hf2, 8'h00);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 40; i++) begin
      exp_cfg[i] = (i / 8 == 2 || i / 8 == 3) ? 8'h04 : 8'h44;
      if (i < 29 || i > 31) begin
        wr(8'hf0, 8'(i / 8 * 16 + i % 8));
        rd(8'hf1, exp_cfg[i]);
        pins(i);
      end
    end
    $display("test reset values done");
    wr(8'hf0, 8'h00);
    wr(8'hf1, 8'h24);
    wr(8'h30, 8'h01);
    wr(8'hf2, 8'h07);
    wr(8'hf6, 8'h01);
    rd(8'hf3, 8'h00);
    pin_level_i[0] <= 1'b1;
    tick(3);
    @(negedge core_clk_i);
    chk({5'h00, irq_o, smi_o, power_wakeup_request_o}, 8'h07, "routed");
    rd(8'hf3, 8'h01);
    @(negedge core_clk_i);
    chk({7'h00, irq_o}, 8'h00, "irq cleared");
    wr(8'hf6, 8'h00);
    pin_level_i[0] <= 1'b0;
    tick(3);
    pin_level_i[0] <= 1'b1;
    tick(3);
    @(negedge core_clk_i);
    chk({7'h00, irq_o}, 8'h00, "masked irq");
    rd(8'hf3, 8'h01);
    wr(8'hf1, 8'h34);
    rd(8'hf3, 8'h01);
    rd(8'hf3, 8'h01);
    wr(8'hf1, 8'h14);
    pin_level_i[0] <= 1'b0;
    wr(8'hf1, 8'h64);
    tick(25);
    rd(8'hf3, 8'h01);
    rd(8'hf3, 8'h00);
    // A change seen on 19 edges is one short of the period
    pin_level_i[0] <= 1'b1;
    tick(19);
    pin_level_i[0] <= 1'b0;
    tick(25);
    rd(8'hf3, 8'h00);
    pin_level_i[0] <= 1'b1;
    tick(19);
    rd(8'hf3, 8'h00);
    rd(8'hf3, 8'h01);
    exp_cfg[0] = 8'h64;
    $display("test events done");
    repeat (6) begin
      v = 8'(rnd());
      wr(8'h30, v);
      rd(8'h30, v & 8'h01);
      wr(8'h61, v);
      rd(8'h61, v & 8'hf0);
      wr(8'h71, v);
      rd(8'h71, {6'h00, v[1], 1'b1});
      wr(8'h75, v);
      rd(8'h75, 8'h04);
      wr(8'hf2, v);
      rd(8'hf2, v & 8'h07);
      wr(8'hf0, v);
      rd(8'hf0, v & 8'h77);
      wr(8'h60, v);
      wr(8'h70, ~v);
      rd(8'h60, v);
      rd(8'h70, ~v);
      chk(base_address_o[15:8], v, "base high");
      chk(base_address_o[7:0], v & 8'hf0, "base low");
      chk(irq_number_o, ~v, "irq number");
      chk({7'h00, irq_type_o}, {7'h00, v[1]}, "irq type");
      chk({7'h00, function_active_o}, v & 8'h01, "activate");
      chk({5'h00, event_routing_o}, v & 8'h07, "routing");
    end
    $display("test registers done");
    repeat (120) begin
      v = 8'(rnd());
      d = 8'(rnd());
      k = v[6:4] * 8 + v[2:0];
      ok = v[6:4] <= 3'h4 && !(v[6:4] == 3'h3 && v[2:0] > 3'h4);
      wr(8'hf0, v);
      pin_level_i[31:16] <= 16'(rnd());
      wr(8'hf1, d);
      if (ok) begin
        exp_cfg[k] = cfg_after(exp_cfg[k], d, v[6:4]);
      end
      rd(8'hf1, ok ? exp_cfg[k] : 8'h00);
      if (ok) begin
        pins(k);
      end
    end
    // Make sure pin 0 is locked before reset must clear it
    wr(8'hf0, 8'h00);
    wr(8'hf1, 8'h0b);
    exp_cfg[0] = cfg_after(exp_cfg[0], 8'h0b, 3'h0);
    rd(8'hf1, exp_cfg[0]);
    pins(0);
    $display("test window done");
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    tick(4);
    exp_cfg[0] = 8'h44;
    rd(8'hf1, 8'h44);
    pins(0);
    rd(8'hf0, 8'h00);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
